// ==== common/prc_pkg.sv ====
// Constants, types and decode helpers for the receive statistics register bank
`default_nettype none
package prc_pkg;
  // Bus and register widths
  localparam int AXI_AW = 32;
  localparam int AXI_DW = 32;
  localparam int REG_W = 16;
  localparam int FAULT_CNT_W = 8;
  localparam int CRC_CNT_W = 16;
  localparam int EXP_AW = 8;
  localparam int EXP_DEPTH = 256;
  // Register indices; byte address is four times the index
  localparam logic [7:0] CNT_IDX = 8'h28;
  localparam logic [7:0] DATA_IDX = 8'h2A;
  localparam logic [7:0] ACC_IDX = 8'h2E;
  localparam logic [7:0] CTRL_IDX = 8'h3C;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  // Field positions
  localparam int SEL_BIT = 15;
  localparam int MODE_BIT = 9;
  localparam int EXP_SEL_HI = 11;
  localparam int EXP_SEL_LO = 8;
  localparam int EXP_NUM_HI = 7;
  // Field values
  localparam logic [3:0] EXP_SEL_OPEN = 4'hF;
  localparam logic [7:0] EXP_INT_NUM = 8'h00;
  localparam logic [7:0] FAULT_MAX = 8'hFF;
  localparam logic [15:0] CRC_MAX = 16'hFFFF;
  // Values after reset
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [7:0] FAULT_RST = 8'h00;
  localparam logic [1:0] LVL_RST = 2'h0;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {REG_NONE, REG_CNT, REG_DATA, REG_ACC, REG_CTRL} prc_reg_e;
  typedef enum logic [1:0] {RD_IDLE, RD_MEM, RD_RESP} prc_rd_state_e;

  // Byte address to register; anything off the word grid or above the map is unmapped
  function automatic prc_reg_e prc_decode(input logic [AXI_AW-1:0] addr);
    logic [7:0] idx;
    idx = addr[IDX_MSB:IDX_LSB];
    if (addr[AXI_AW-1:IDX_MSB+1] != 22'h000000 || addr[1:0] != 2'h0)
      return REG_NONE;
    else if (idx == CNT_IDX)
      return REG_CNT;
    else if (idx == DATA_IDX)
      return REG_DATA;
    else if (idx == ACC_IDX)
      return REG_ACC;
    else if (idx == CTRL_IDX)
      return REG_CTRL;
    else
      return REG_NONE;
  endfunction

  // Byte-lane merge of a write into a 16-bit register
  function automatic logic [REG_W-1:0] prc_merge(input logic [REG_W-1:0] old_v,
                                                 input logic [REG_W-1:0] new_v, input logic [1:0] strb);
    prc_merge = {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
  endfunction
endpackage
`default_nettype wire

// ==== common/prc_mem_if.sv ====
// Port bundle between the register bank and the expansion register store
`timescale 1ns/100ps
`default_nettype none
interface prc_mem_if;
  logic we;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport host (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== logic/prc_sat_counter.sv ====
// Saturating clear-on-read event counter
`timescale 1ns/100ps
`default_nettype none
module prc_sat_counter #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic inc_i,
  input wire logic clr_i,
  output logic [W-1:0] count_o
);
  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
  localparam logic [W-1:0] ALL = {W{1'b1}};

  // Clear on read; an event in the clearing cycle still counts
  // hold at max
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      count_o <= '0;
    else if (clr_i)
      count_o <= inc_i ? ONE : '0;
    else if (inc_i && count_o != ALL)
      count_o <= count_o + ONE;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_sat;
    count_o == ALL && !clr_i |=> count_o == ALL;
  endproperty
  a_sat: assert property (p_sat) else $error("counter left its ceiling");
  property p_step;
    inc_i && !clr_i && count_o != ALL |=> count_o == $past(count_o) + ONE;
  endproperty
  a_step: assert property (p_step) else $error("counter missed an event");
  c_sat: cover property (inc_i && count_o == ALL);
endmodule
`default_nettype wire

// ==== logic/prc_exp_mem.sv ====
// Expansion register store with registered read data
`timescale 1ns/100ps
`default_nettype none
module prc_exp_mem (
  input wire logic clk_i,
  prc_mem_if.mem mem_p
);
  import prc_pkg::*;
  logic [REG_W-1:0] store [EXP_DEPTH];

  // Write port; read data lags the address by one edge
  always_ff @(posedge clk_i)
  begin
    if (mem_p.we)
      store[mem_p.addr] <= mem_p.wdata;
    mem_p.rdata <= store[mem_p.addr];
  end
endmodule
`default_nettype wire

// ==== logic/prc_rx_stat_regs.sv ====
// AXI4-Lite register bank: receive fault and CRC counters plus expansion window
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module prc_rx_stat_regs (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [prc_pkg::AXI_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [prc_pkg::AXI_DW-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [prc_pkg::AXI_AW-1:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [prc_pkg::AXI_DW-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  input wire logic local_rx_fault_i,
  input wire logic remote_rx_fault_i,
  input wire logic rx_crc_err_i,
  input wire logic [prc_pkg::REG_W-1:0] exp_int_status_i
);
  import prc_pkg::*;

  logic [REG_W-1:0] acc_reg;
  logic [REG_W-1:0] ctrl_reg;
  logic aw_full;
  logic w_full;
  prc_reg_e aw_reg;
  logic [REG_W-1:0] w_data;
  logic [1:0] w_strb;
  logic bvalid;
  logic [1:0] bresp;
  prc_rd_state_e rd_state;
  logic [REG_W-1:0] rdata;
  logic [1:0] rresp;
  logic rd_exp_zero;
  logic [1:0] fault_lvl;
  logic [1:0] fault_prev;
  logic [1:0] fault_inc;
  logic [FAULT_CNT_W-1:0] fault_cnt [2];
  logic [CRC_CNT_W-1:0] crc_cnt;
  logic crc_inc;
  logic cnt_live;
  logic view_crc;
  logic window_open;
  logic wr_fire;
  logic ar_take;
  prc_reg_e ar_reg;
  logic rd_clr;
  logic rd_clr_f;
  logic rd_clr_c;
  logic [REG_W-1:0] cnt_view;

  prc_mem_if mem_bus ();

  prc_exp_mem u_mem (
    .clk_i(clk_i),
    .mem_p(mem_bus.mem)
  );

  // Mode and view decode from the control register
  assign cnt_live = ~ctrl_reg[MODE_BIT];
  assign view_crc = ctrl_reg[SEL_BIT];
  assign window_open = acc_reg[EXP_SEL_HI:EXP_SEL_LO] == EXP_SEL_OPEN;

  // Bus handshakes; one read and one write in flight at most
  assign s_axi_awready_o = ~aw_full;
  assign s_axi_wready_o = ~w_full;
  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;
  assign s_axi_arready_o = rd_state == RD_IDLE;
  assign s_axi_rvalid_o = rd_state == RD_RESP;
  assign s_axi_rdata_o = {16'h0000, rdata};
  assign s_axi_rresp_o = rresp;
  assign wr_fire = aw_full & w_full & ~bvalid;
  assign ar_take = s_axi_arvalid_i & (rd_state == RD_IDLE);
  assign ar_reg = prc_decode(s_axi_araddr_i);

  // clear only the counters the read shows
  assign rd_clr = ar_take & (ar_reg == REG_CNT) & cnt_live;
  assign rd_clr_f = rd_clr & ~view_crc;
  assign rd_clr_c = rd_clr & view_crc;

  // Index 1 is the local receiver, index 0 the remote one
  assign fault_lvl = {local_rx_fault_i, remote_rx_fault_i};

  // Previous fault level for entry detection
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      fault_prev <= LVL_RST;
    else
      fault_prev <= fault_lvl;
  end

  // Fault counters; a long fault must not run the count up
  for (genvar g = 0; g < 2; g++)
  begin : g_fault
    assign fault_inc[g] = cnt_live & ~view_crc & fault_lvl[g] & ~fault_prev[g];
    prc_sat_counter #(.W(FAULT_CNT_W)) u_cnt (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .inc_i(fault_inc[g]),
      .clr_i(rd_clr_f),
      .count_o(fault_cnt[g])
    );
  end

  assign crc_inc = cnt_live & view_crc & rx_crc_err_i;
  prc_sat_counter #(.W(CRC_CNT_W)) u_crc (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .inc_i(crc_inc),
    .clr_i(rd_clr_c),
    .count_o(crc_cnt)
  );

  assign cnt_view = view_crc ? crc_cnt : {fault_cnt[1], fault_cnt[0]};

  // window number drives the store address
  assign mem_bus.addr = acc_reg[EXP_NUM_HI:0];
  assign mem_bus.wdata = w_data;
  // entry zero is live status, so writes to it are dropped
  assign mem_bus.we = wr_fire & (aw_reg == REG_DATA) & window_open & (acc_reg[EXP_NUM_HI:0] != EXP_INT_NUM)
                      & (w_strb == 2'h3);

  // Write address and data are latched independently, then applied together
  // An unmapped write still answers, with an error code, so the master never hangs
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_reg <= REG_NONE;
      w_data <= REG_RST;
      w_strb <= 2'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i && !aw_full)
      begin
        aw_full <= 1'b1;
        aw_reg <= prc_decode(s_axi_awaddr_i);
      end
      else if (wr_fire)
        aw_full <= 1'b0;
      if (s_axi_wvalid_i && !w_full)
      begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata_i[REG_W-1:0];
        w_strb <= s_axi_wstrb_i[1:0];
      end
      else if (wr_fire)
        w_full <= 1'b0;
      if (wr_fire)
      begin
        bvalid <= 1'b1;
        bresp <= (aw_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (bvalid && s_axi_bready_i)
        bvalid <= 1'b0;
    end
  end

  // Access register; reserved top bits are stored as written
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      acc_reg <= REG_RST;
    else if (wr_fire && aw_reg == REG_ACC)
      acc_reg <= prc_merge(acc_reg, w_data, w_strb);
  end

  // Control register: counting mode and view select
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      ctrl_reg <= REG_RST;
    else if (wr_fire && aw_reg == REG_CTRL)
      ctrl_reg <= prc_merge(ctrl_reg, w_data, w_strb);
  end

  // Read path; expansion reads take an extra edge for the store's read register
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rd_state <= RD_IDLE;
      rdata <= REG_RST;
      rresp <= RESP_OKAY;
      rd_exp_zero <= 1'b0;
    end
    else
    begin
      case (rd_state)
        RD_IDLE:
        begin
          if (ar_take)
          begin
            rresp <= RESP_OKAY;
            rd_exp_zero <= acc_reg[EXP_NUM_HI:0] == EXP_INT_NUM;
            rd_state <= (ar_reg == REG_DATA && window_open) ? RD_MEM : RD_RESP;
            if (ar_reg == REG_CNT)
              rdata <= cnt_live ? cnt_view : REG_RST;
            else if (ar_reg == REG_ACC)
              rdata <= acc_reg;
            else if (ar_reg == REG_CTRL)
              rdata <= ctrl_reg;
            else if (ar_reg == REG_DATA)
              rdata <= REG_RST;
            else
            begin
              rdata <= REG_RST;
              rresp <= RESP_SLVERR;
            end
          end
        end
        RD_MEM:
        begin
          rdata <= rd_exp_zero ? exp_int_status_i : mem_bus.rdata;
          rd_state <= RD_RESP;
        end
        RD_RESP:
        begin
          if (s_axi_rready_i)
            rd_state <= RD_IDLE;
        end
        default:
          rd_state <= RD_IDLE;
      endcase
    end
  end

  // Checks on counting, clearing and the window; the bus handshake is left to the bench
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_local_inc;
    fault_inc[1] && !rd_clr_f && fault_cnt[1] != FAULT_MAX |=> fault_cnt[1] == $past(fault_cnt[1]) + 8'h01;
  endproperty
  a_local_inc: assert property (p_local_inc) else $error("local fault entry not counted");
  property p_remote_inc;
    cnt_live && !view_crc && remote_rx_fault_i && !fault_prev[0]
      && !rd_clr_f && fault_cnt[0] != FAULT_MAX |=> fault_cnt[0] == $past(fault_cnt[0]) + 8'h01;
  endproperty
  a_remote_inc: assert property (p_remote_inc) else $error("remote fault entry not counted");
  property p_hold_fault;
    fault_lvl[1] && fault_prev[1] && !rd_clr_f |=> fault_cnt[1] == $past(fault_cnt[1]);
  endproperty
  a_hold_fault: assert property (p_hold_fault) else $error("held fault counted again");
  property p_clear;
    rd_clr_f && fault_inc == 2'h0 |=> fault_cnt[1] == FAULT_RST && fault_cnt[0] == FAULT_RST;
  endproperty
  a_clear: assert property (p_clear) else $error("fault pair not cleared by read");
  property p_crc_inc;
    cnt_live && view_crc && rx_crc_err_i && !rd_clr_c && crc_cnt != CRC_MAX |=> crc_cnt == $past(crc_cnt) + 16'h0001;
  endproperty
  a_crc_inc: assert property (p_crc_inc) else $error("CRC error not counted");
  property p_view;
    ar_take && ar_reg == REG_CNT && cnt_live |=> s_axi_rvalid_o
      && rdata == ($past(view_crc) ? $past(crc_cnt) : {$past(fault_cnt[1]), $past(fault_cnt[0])});
  endproperty
  a_view: assert property (p_view) else $error("wrong counter view returned");
  property p_reset_zero;
    disable iff (1'b0) $past(reset_i) |-> crc_cnt == REG_RST && fault_cnt[1] == FAULT_RST && fault_cnt[0] == FAULT_RST;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("counter not zero after reset");
  property p_window;
    ar_take && ar_reg == REG_DATA && !window_open |=> s_axi_rvalid_o && rdata == REG_RST;
  endproperty
  a_window: assert property (p_window) else $error("closed window returned data");
  property p_exp_read;
    ar_take && ar_reg == REG_DATA && window_open && acc_reg[EXP_NUM_HI:0] != EXP_INT_NUM
      |=> rd_state == RD_MEM ##1 s_axi_rvalid_o && rdata == $past(mem_bus.rdata);
  endproperty
  a_exp_read: assert property (p_exp_read) else $error("expansion read misrouted");
  property p_exp_zero;
    rd_state == RD_MEM && rd_exp_zero |=> rdata == $past(exp_int_status_i);
  endproperty
  a_exp_zero: assert property (p_exp_zero) else $error("entry zero is not status");

  // Counters stand still whenever the mode or the view keeps them out of play; also mode-off reads, CRC clear, held remote fault
  property p_mode_hold;
    !cnt_live |=> fault_cnt[1] == $past(fault_cnt[1]) && fault_cnt[0] == $past(fault_cnt[0])
      && crc_cnt == $past(crc_cnt);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("counter moved with counting off");
  property p_mode_read;
    ar_take && ar_reg == REG_CNT && !cnt_live |=> s_axi_rvalid_o && rdata == REG_RST;
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("counter read with counting off not zero");
  property p_crc_idle;
    !view_crc |=> crc_cnt == $past(crc_cnt);
  endproperty
  a_crc_idle: assert property (p_crc_idle) else $error("CRC counter moved in fault view");
  property p_fault_idle;
    view_crc |=> fault_cnt[1] == $past(fault_cnt[1]) && fault_cnt[0] == $past(fault_cnt[0]);
  endproperty
  a_fault_idle: assert property (p_fault_idle) else $error("fault pair moved in CRC view");
  property p_crc_clear;
    rd_clr_c && !crc_inc |=> crc_cnt == REG_RST;
  endproperty
  a_crc_clear: assert property (p_crc_clear) else $error("CRC counter not cleared by read");
  property p_hold_remote;
    fault_lvl[0] && fault_prev[0] && !rd_clr_f |=> fault_cnt[0] == $past(fault_cnt[0]);
  endproperty
  a_hold_remote: assert property (p_hold_remote) else $error("held remote fault counted again");
  c_fault_read: cover property (rd_clr_f && fault_cnt[1] != FAULT_RST);
  c_crc_read: cover property (rd_clr_c && crc_cnt != REG_RST);
  c_exp_read: cover property (rd_state == RD_MEM && !rd_exp_zero);
  c_exp_write: cover property (mem_bus.we);
endmodule
`default_nettype wire

// ==== tb/prc_phy_model.sv ====
// Receive-side event source standing in for the local and remote receivers
`timescale 1ns/100ps
`default_nettype none
module prc_phy_model (
  input wire logic clk_i,
  output logic local_o,
  output logic remote_o,
  output logic crc_o
);
  // Lines quiet from time zero
  initial
  begin
    local_o = 1'b0;
    remote_o = 1'b0;
    crc_o = 1'b0;
  end

  // fault level persists
  // Fault held for hold cycles per entry, so a per-cycle counter would overcount once hold exceeds one
  task automatic entries(input bit remote, input int n, input int hold);
    repeat (n)
    begin
      @(posedge clk_i);
      if (remote)
        remote_o <= 1'b1;
      else
        local_o <= 1'b1;
      repeat (hold) @(posedge clk_i);
      local_o <= 1'b0;
      remote_o <= 1'b0;
    end
    @(posedge clk_i);
  endtask

  // Back-to-back CRC error pulses, one count per high cycle
  task automatic crc_pulses(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      crc_o <= 1'b1;
    end
    @(posedge clk_i);
    crc_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb/prc_rx_stat_regs_bench.sv ====
// Self-checking bench for the receive statistics register bank
`timescale 1ns/100ps
`default_nettype none
module prc_rx_stat_regs_bench;
  import prc_pkg::*;
  localparam logic [31:0] A_CNT = {22'h000000, CNT_IDX, 2'h0};
  localparam logic [31:0] A_DATA = {22'h000000, DATA_IDX, 2'h0};
  localparam logic [31:0] A_ACC = {22'h000000, ACC_IDX, 2'h0};
  localparam logic [31:0] A_CTRL = {22'h000000, CTRL_IDX, 2'h0};
  localparam logic [15:0] STATUS = 16'hC3A5;
  logic [15:0] status = STATUS;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] awaddr = 32'h00000000;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] araddr = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic loc, rem, crc;
  logic [31:0] got;
  logic [1:0] resp;
  int errors = 0;
  int checked = 0;

  // Design under test
  prc_rx_stat_regs i_dut (
    .clk_i(clk_i), .reset_i(reset_i),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_araddr_i(araddr),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .local_rx_fault_i(loc), .remote_rx_fault_i(rem), .rx_crc_err_i(crc), .exp_int_status_i(status)
  );

  // Receiver event source
  prc_phy_model i_phy (
    .clk_i(clk_i), .local_o(loc), .remote_o(rem), .crc_o(crc)
  );

  // 100 MHz clock
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // AXI write; address and data offered together, each released when taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bit a_done;
    bit w_done;
    a_done = 0;
    w_done = 0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(a_done && w_done))
    begin
      @(posedge clk_i);
      if (!a_done && awready === 1'b1)
      begin
        a_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1)
      begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk_i);
    resp = bresp;
    bready <= 1'b0;
  endtask

  // AXI read; data and response taken at the first edge that shows rvalid high
  task automatic rd(input logic [31:0] a);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    got = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // Verdict and end of run
  task automatic end_sim();
    if (errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Hang guard, well above the roughly 1300 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_i);
    errors++;
    end_sim();
  end

  // Test sequence
  initial
  begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(A_CNT);
    chk(got, 32'h00000000);
    chk({30'h0, resp}, {30'h0, RESP_OKAY});
    rd(A_ACC);
    chk(got, 32'h00000000);
    i_phy.entries(1'b0, 2, 4);
    i_phy.entries(1'b1, 3, 3);
    rd(A_CNT);
    chk(got, 32'h00000203);
    rd(A_CNT);
    chk(got, 32'h00000000);
    wr(A_CTRL, 32'h00008000);
    i_phy.crc_pulses(4);
    i_phy.entries(1'b0, 1, 2);
    rd(A_CNT);
    chk(got, 32'h00000004);
    rd(A_CNT);
    chk(got, 32'h00000000);
    wr(A_CTRL, 32'h00000000);
    rd(A_CNT);
    chk(got, 32'h00000000);
    i_phy.entries(1'b0, 300, 1);
    i_phy.entries(1'b1, 256, 1);
    rd(A_CNT);
    chk(got, {16'h0000, FAULT_MAX, FAULT_MAX});
    i_phy.entries(1'b1, 2, 1);
    wr(A_CTRL, 32'h00000200);
    i_phy.entries(1'b1, 2, 1);
    i_phy.entries(1'b0, 2, 1);
    rd(A_CNT);
    chk(got, 32'h00000000);
    wr(A_CTRL, 32'h00000000);
    rd(A_CNT);
    chk(got, 32'h00000002);
    // window opened with all ones only
    wr(A_ACC, 32'h00000F05);
    rd(A_ACC);
    chk(got, 32'h00000F05);
    wr(A_DATA, 32'h00001234);
    wr(A_ACC, 32'h00000F06);
    wr(A_DATA, 32'h00005678);
    rd(A_DATA);
    chk(got, 32'h00005678);
    wr(A_ACC, 32'h00000F05);
    rd(A_DATA);
    chk(got, 32'h00001234);
    wr(A_ACC, {24'h00000F, EXP_INT_NUM});
    rd(A_DATA);
    chk(got, {16'h0000, STATUS});
    wr(A_DATA, 32'h00001111);
    status <= 16'h5A3C;
    rd(A_DATA);
    chk(got, 32'h00005A3C);
    wr(A_ACC, 32'h00000005);
    rd(A_DATA);
    chk(got, 32'h00000000);
    wr(A_DATA, 32'h00009999);
    wr(A_ACC, 32'h00000F05);
    rd(A_DATA);
    chk(got, 32'h00001234);
    // second reset with live counts and an open window
    i_phy.entries(1'b0, 2, 1);
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(A_CNT);
    chk(got, 32'h00000000);
    rd(A_ACC);
    chk(got, 32'h00000000);
    wr(A_ACC, 32'h00000000);
    rd(A_ACC);
    chk(got, 32'h00000000);
    rd(32'h00000004);
    chk({resp, got[29:0]}, {RESP_SLVERR, 30'h0});
    wr(32'h00000004, 32'h0000FFFF);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    end_sim();
  end
endmodule
`default_nettype wire
